// [rtl/irq_out_pkg.sv]
// package: register map, field layout and timing constants of the interrupt output logic
package irq_out_pkg;

    // =====================================================================
    // register bus geometry
    localparam int ADDR_W = 8;   // byte address width
    localparam int DATA_W = 32;  // register data width

    // =====================================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h0c;        // general_mode_control
    localparam logic [ADDR_W-1:0] OFS_CFG = 8'h10;         // irq_output_config
    localparam logic [ADDR_W-1:0] OFS_USB_EN = 8'h14;      // usb interrupt enable
    localparam logic [ADDR_W-1:0] OFS_USB_STATUS = 8'h18;  // usb interrupt status
    localparam logic [ADDR_W-1:0] OFS_DMA_EN = 8'h1c;      // dma interrupt enable
    localparam logic [ADDR_W-1:0] OFS_DMA_REASON = 8'h20;  // dma interrupt reason

    // =====================================================================
    // register widths
    localparam int MODE_W = 16;    // general_mode_control width
    localparam int CFG_W = 8;      // irq_output_config width
    localparam int USB_W = 32;     // usb status and enable width
    localparam int DMA_W = 16;     // dma reason and enable width
    localparam int GEN_EV_W = 16;  // general usb events, low status bits
    localparam int PIPE_N = 3;     // control, in and out pipe groups

    // =====================================================================
    // field positions
    localparam int MODE_GLOBAL_EN_BIT = 3;  // global_irq_enable in general_mode_control
    localparam int CFG_POL_BIT = 0;         // irq_polarity_sel: 1 = active high
    localparam int CFG_LVL_BIT = 1;         // irq_level_pulse_sel: 1 = pulse
    localparam int CFG_CTRL_LSB = 2;        // ctrl_pipe_irq_mode [3:2]
    localparam int CFG_IN_LSB = 4;          // in_pipe_irq_mode [5:4]
    localparam int CFG_OUT_LSB = 6;         // out_pipe_irq_mode [7:6]
    localparam int USB_PIPE_LSB = 16;       // pipe status bits 16 (ctrl), 17 (in), 18 (out)

    // =====================================================================
    // reset values
    localparam logic [MODE_W-1:0] MODE_RST = 16'h0000;  // global enable off
    localparam logic [CFG_W-1:0] CFG_RST = 8'h00;       // active low, level signalling
    localparam logic [USB_W-1:0] USB_RST = 32'h0000_0000;
    localparam logic [DMA_W-1:0] DMA_RST = 16'h0000;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // =====================================================================
    // pipe interrupt modes
    localparam logic [1:0] PMODE_ACK_NAK = 2'h0;    // interrupt on ack and every nak
    localparam logic [1:0] PMODE_ACK_ONLY = 2'h1;   // interrupt on ack only
    localparam logic [1:0] PMODE_ACK_FNAK = 2'h2;   // ack and the first nak after an ack
    localparam logic [1:0] PMODE_RESERVED = 2'h3;   // behaves as ack only

    // =====================================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;  // ref_clk period
    localparam int PULSE_NS = 60;       // pulse width on the interrupt pin
    localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PCNT_W = 2;          // width of the pulse counter
    localparam logic [PCNT_W-1:0] PCNT_LOAD = PCNT_W'(PULSE_CYCLES);
    localparam logic [PCNT_W-1:0] PCNT_ZERO = 2'h0;
    localparam logic [PCNT_W-1:0] PCNT_ONE = 2'h1;

endpackage

// [rtl/irq_pulse_gen.sv]
// module: fixed-width pulse generator for the pulse signalling style of the interrupt pin
`timescale 1ns/1ps
module irq_pulse_gen
    import irq_out_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,  // one-cycle trigger
    output logic busy        // high for PULSE_CYCLES cycles
);

    // =====================================================================
    // counter
    logic [PCNT_W-1:0] cnt;  // cycles of pulse left

    // load on a trigger; a trigger during a pulse is merged into it, so
    // the pin never shows a pulse longer or shorter than the fixed width
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt <= PCNT_ZERO;
        end else if (start && cnt == PCNT_ZERO) begin
            cnt <= PCNT_LOAD;
        end else if (cnt != PCNT_ZERO) begin
            cnt <= cnt - PCNT_ONE;
        end
    end

    // busy flag kept in its own flop so the caller sees a clean level
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (start && cnt == PCNT_ZERO) begin
            busy <= 1'b1;
        end else if (cnt == PCNT_ONE) begin
            busy <= 1'b0;
        end
    end

endmodule

// [rtl/usb_dev_irq_output_logic.sv]
// module: interrupt latching, masking and interrupt pin output of the usb device controller
// Operation
// - polarity and level/pulse select in config
// - pin newly asserted only with global enable set
// - reset gives active low, level signalling
// - pulse mode: 60 ns pulse per rise
// - each event sets its own status bit
// - enable bits gate latched events to pin
// - three 2-bit pipe mode fields govern pipes
// - event latched even when globally disabled
// - enabling with pending bit asserts pin in level style only; pulse style gives no pulse
// - disabling global enable keeps pin asserted
// - level style: pin deasserts only when no enabled status bit is set; a pulse ends after 60 ns
`timescale 1ns/1ps
module usb_dev_irq_output_logic (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [irq_out_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [irq_out_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [irq_out_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [irq_out_pkg::GEN_EV_W-1:0] usb_event,
    input wire logic [irq_out_pkg::PIPE_N-1:0] pipe_ack,
    input wire logic [irq_out_pkg::PIPE_N-1:0] pipe_nak,
    input wire logic [irq_out_pkg::DMA_W-1:0] dma_event,
    output logic irq_pin
);
    import irq_out_pkg::*;

    // =====================================================================
    // decode helpers
    // address match with a write or read strobe
    function automatic logic hit(input logic stb, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        hit = stb && (a == ofs);
    endfunction

    // decides whether a pipe handshake raises its status bit
    function automatic logic pipe_fire(input logic [1:0] mode, input logic ack,
                                       input logic nak, input logic nak_seen);
        logic f;
        f = ack;
        unique case (mode)
            PMODE_ACK_NAK: f = ack || nak;
            PMODE_ACK_ONLY: f = ack;
            PMODE_ACK_FNAK: f = ack || (nak && !nak_seen);
            PMODE_RESERVED: f = ack;
        endcase
        pipe_fire = f;
    endfunction

    // =====================================================================
    // registers
    logic [MODE_W-1:0] mode_reg;     // general_mode_control
    logic [CFG_W-1:0] cfg_reg;       // irq_output_config
    logic [USB_W-1:0] usb_en;        // usb interrupt enable
    logic [USB_W-1:0] usb_status;    // usb interrupt status
    logic [DMA_W-1:0] dma_en;        // dma interrupt enable
    logic [DMA_W-1:0] dma_reason;    // dma interrupt reason
    logic [PIPE_N-1:0] nak_seen;     // a nak already seen since last ack, in any mode
    logic irq_active;                // level-style interrupt condition held
    logic any_irq_q;                 // any_irq one cycle ago, for edge detect
    logic pulse_busy;                // pulse generator output

    // decoded fields
    logic global_irq_enable;
    logic irq_polarity_sel;
    logic irq_level_pulse_sel;
    logic [1:0] pipe_mode [PIPE_N];  // ctrl, in, out pipe modes
    assign global_irq_enable = mode_reg[MODE_GLOBAL_EN_BIT];
    assign irq_polarity_sel = cfg_reg[CFG_POL_BIT];
    assign irq_level_pulse_sel = cfg_reg[CFG_LVL_BIT];
    assign pipe_mode[0] = cfg_reg[CFG_CTRL_LSB +: 2];
    assign pipe_mode[1] = cfg_reg[CFG_IN_LSB +: 2];
    assign pipe_mode[2] = cfg_reg[CFG_OUT_LSB +: 2];

    // =====================================================================
    // event collection
    logic [USB_W-1:0] usb_set;       // set requests for usb status
    logic [PIPE_N-1:0] pipe_set;     // pipe bits after mode filtering
    genvar gp;
    generate
        for (gp = 0; gp < PIPE_N; gp++) begin : g_pipe
            assign pipe_set[gp] = pipe_fire(pipe_mode[gp], pipe_ack[gp], pipe_nak[gp],
                                            nak_seen[gp]);
        end
    endgenerate
    assign usb_set = {{(USB_W - GEN_EV_W - PIPE_N){1'b0}}, pipe_set, usb_event};

    // first-nak tracking: an ack rearms, any nak disarms, reported or not
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nak_seen <= '0;
        end else begin
            nak_seen <= (nak_seen | pipe_nak) & ~pipe_ack;
        end
    end

    // =====================================================================
    // control registers
    // the whole word is written; no byte lanes exist on this port
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_reg <= MODE_RST;
            cfg_reg <= CFG_RST;
            usb_en <= USB_RST;
            dma_en <= DMA_RST;
        end else begin
            if (hit(reg_wr, reg_addr, OFS_MODE)) begin
                mode_reg <= reg_wdata[MODE_W-1:0];
            end
            if (hit(reg_wr, reg_addr, OFS_CFG)) begin
                cfg_reg <= reg_wdata[CFG_W-1:0];
            end
            if (hit(reg_wr, reg_addr, OFS_USB_EN)) begin
                usb_en <= reg_wdata[USB_W-1:0];
            end
            if (hit(reg_wr, reg_addr, OFS_DMA_EN)) begin
                dma_en <= reg_wdata[DMA_W-1:0];
            end
        end
    end

    // =====================================================================
    // status registers
    // latching ignores the global enable so nothing is lost while masked;
    // the set term is or-ed last so an event beats a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            usb_status <= USB_RST;
        end else if (hit(reg_wr, reg_addr, OFS_USB_STATUS)) begin
            usb_status <= (usb_status & ~reg_wdata[USB_W-1:0]) | usb_set;
        end else begin
            usb_status <= usb_status | usb_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dma_reason <= DMA_RST;
        end else if (hit(reg_wr, reg_addr, OFS_DMA_REASON)) begin
            dma_reason <= (dma_reason & ~reg_wdata[DMA_W-1:0]) | dma_event;
        end else begin
            dma_reason <= dma_reason | dma_event;
        end
    end

    // =====================================================================
    // interrupt condition
    logic any_irq;  // or of all enabled status bits
    assign any_irq = (|(usb_status & usb_en)) || (|(dma_reason & dma_en));

    // asserted when enabled and pending; only an empty enabled status releases it,
    // so dropping the global enable does not pull the pin back
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_active <= 1'b0;
        end else if (!any_irq) begin
            irq_active <= 1'b0;
        end else if (global_irq_enable) begin
            irq_active <= 1'b1;
        end
    end

    // edge detect for the pulse style
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            any_irq_q <= 1'b0;
        end else begin
            any_irq_q <= any_irq;
        end
    end

    // the enable is looked at only at the rise itself: a rise while masked is
    // not replayed later, so software must clear and re-raise to get a pulse
    logic pulse_start;  // rise of the combined interrupt while enabled
    assign pulse_start = any_irq && !any_irq_q && global_irq_enable && irq_level_pulse_sel;

    irq_pulse_gen u_pulse (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(pulse_start),
        .busy(pulse_busy)
    );

    // =====================================================================
    // pin driver
    logic next_irq_pin;  // pin level for the next cycle
    always_comb begin
        if (irq_level_pulse_sel) begin
            next_irq_pin = irq_polarity_sel ? pulse_busy : !pulse_busy;
        end else begin
            next_irq_pin = irq_polarity_sel ? irq_active : !irq_active;
        end
    end

    // reset value is the inactive level of an active-low pin
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_pin <= 1'b1;
        end else begin
            irq_pin <= next_irq_pin;
        end
    end

    // =====================================================================
    // read port: data one cycle after the strobe, zero for unmapped
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= RDATA_RST;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OFS_MODE: reg_rdata <= DATA_W'(mode_reg);
                OFS_CFG: reg_rdata <= DATA_W'(cfg_reg);
                OFS_USB_EN: reg_rdata <= usb_en;
                OFS_USB_STATUS: reg_rdata <= usb_status;
                OFS_DMA_EN: reg_rdata <= DATA_W'(dma_en);
                OFS_DMA_REASON: reg_rdata <= DATA_W'(dma_reason);
                default: reg_rdata <= RDATA_RST;
            endcase
        end else begin
            reg_rdata <= RDATA_RST;
        end
    end

    // =====================================================================
    // assertions
    // they watch only what this block drives; the pin follows config one cycle
    // late, so a config write in the checked cycle is let through on purpose
    AST_RESET_DEFAULT: assert property (@(posedge ref_clk)
        rst |=> (!irq_polarity_sel && !irq_level_pulse_sel && irq_pin))
        else $error("config not active low level after reset");

    AST_CFG_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
        hit(reg_wr, reg_addr, OFS_CFG) |=>
        (irq_polarity_sel == $past(reg_wdata[CFG_POL_BIT])) &&
        (irq_level_pulse_sel == $past(reg_wdata[CFG_LVL_BIT])))
        else $error("config write not taken");

    AST_NO_GLOBAL: assert property (@(posedge ref_clk) disable iff (rst)
        (!global_irq_enable && !irq_active) |=> !irq_active)
        else $error("interrupt raised without global enable");

    AST_PULSE_WIDTH: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(pulse_busy) |-> pulse_busy [*3] ##1 !pulse_busy)
        else $error("pulse width not three cycles");

    AST_EVENT_LATCH: assert property (@(posedge ref_clk) disable iff (rst)
        (dma_event != '0) |=> ((dma_reason & $past(dma_event)) == $past(dma_event)))
        else $error("dma event not latched");

    AST_ENABLE_GATE: assert property (@(posedge ref_clk) disable iff (rst)
        (usb_en == '0 && dma_en == '0) |-> !any_irq)
        else $error("masked event reached interrupt condition");

    AST_PIPE_ACK_ONLY: assert property (@(posedge ref_clk) disable iff (rst)
        (pipe_mode[0] == PMODE_ACK_ONLY && pipe_nak[0] && !pipe_ack[0] &&
         !usb_status[USB_PIPE_LSB]) |=> !usb_status[USB_PIPE_LSB])
        else $error("nak raised control pipe bit in ack-only mode");

    AST_LEVEL_ASSERT: assert property (@(posedge ref_clk) disable iff (rst)
        (global_irq_enable && any_irq && !irq_level_pulse_sel && !$past(irq_level_pulse_sel))
        |=> irq_active ##1 (irq_pin == irq_polarity_sel || $changed(cfg_reg) ||
        $past(irq_level_pulse_sel)))
        else $error("pending interrupt not asserted on pin");

    AST_HOLD_AFTER_DISABLE: assert property (@(posedge ref_clk) disable iff (rst)
        (irq_active && any_irq) |=> irq_active)
        else $error("interrupt dropped while still pending");

    AST_DEASSERT: assert property (@(posedge ref_clk) disable iff (rst)
        !any_irq |=> !irq_active)
        else $error("interrupt held with no pending bit");

    AST_W1C: assert property (@(posedge ref_clk) disable iff (rst)
        (hit(reg_wr, reg_addr, OFS_DMA_REASON) && dma_event == '0) |=>
        (dma_reason == ($past(dma_reason) & ~$past(reg_wdata[DMA_W-1:0]))))
        else $error("write one to clear failed");

    // a repeated nak in first-nak mode must leave the control pipe bit alone
    AST_NAK_FIRST: assert property (@(posedge ref_clk) disable iff (rst)
        (pipe_mode[0] == PMODE_ACK_FNAK && pipe_nak[0] && nak_seen[0] && !pipe_ack[0] &&
         !usb_status[USB_PIPE_LSB]) |=> !usb_status[USB_PIPE_LSB])
        else $error("repeated nak raised control pipe bit");

    AST_USB_LATCH: assert property (@(posedge ref_clk) disable iff (rst)
        (usb_event != '0) |=>
        ((usb_status[GEN_EV_W-1:0] & $past(usb_event)) == $past(usb_event)))
        else $error("usb event not latched");

    AST_NO_PULSE_DISABLED: assert property (@(posedge ref_clk) disable iff (rst)
        (!global_irq_enable && !pulse_busy) |=> !pulse_busy)
        else $error("pulse started without global enable");

    // nothing pending in level style: the pin is inactive two edges later
    AST_LEVEL_RELEASE: assert property (@(posedge ref_clk) disable iff (rst)
        (!any_irq && !irq_level_pulse_sel) ##1 $stable(cfg_reg) |=>
        (irq_pin != irq_polarity_sel || $changed(cfg_reg)))
        else $error("pin still active with nothing pending");

    AST_PULSE_PIN: assert property (@(posedge ref_clk) disable iff (rst)
        irq_level_pulse_sel |=>
        (irq_pin == (irq_polarity_sel == $past(pulse_busy)) || $changed(cfg_reg)))
        else $error("pin does not follow the pulse");

endmodule

// [tb/irq_host_model.sv]
// host side model: interrupt input of the microcontroller that watches the interrupt pin
`timescale 1ns/1ps
module irq_host_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic irq_pin,
    input wire logic active_high,
    output logic [7:0] run_len,
    output logic [7:0] run_count
);
    // =====================================================================
    // activity measurement
    logic seen;  // pin at the level the host treats as active
    logic [7:0] cur_len;  // cycles of the run in progress
    assign seen = (irq_pin == active_high);
    // the host samples only on clock edges, so a run is measured in whole cycles
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cur_len <= 8'h00;
            run_len <= 8'h00;
            run_count <= 8'h00;
        end else if (seen) begin
            cur_len <= cur_len + 8'h01;
            // a new run starts: count it once
            if (cur_len == 8'h00) begin
                run_count <= run_count + 8'h01;
            end
        end else begin
            // run ended: keep its length for the bench
            if (cur_len != 8'h00) begin
                run_len <= cur_len;
            end
            cur_len <= 8'h00;
        end
    end
endmodule

// [tb/usb_dev_irq_output_logic_tb.sv]
// testbench: register, event and pin behaviour of the interrupt output logic
`timescale 1ns/1ps
module usb_dev_irq_output_logic_tb import irq_out_pkg::*;;
    // =====================================================================
    // signals
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [GEN_EV_W-1:0] usb_event = 16'h0;
    logic [PIPE_N-1:0] pipe_ack = 3'h0;
    logic [PIPE_N-1:0] pipe_nak = 3'h0;
    logic [DMA_W-1:0] dma_event = 16'h0;
    logic irq_pin;
    logic pol = 1'b0;  // polarity the host model expects
    logic [7:0] run_len;
    logic [7:0] run_count;
    logic [7:0] c0;  // pulse count baseline
    logic [15:0] rnd = 16'h003c;  // random state, fixed seed
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int b;
    int b2;

    always #10 ref_clk = ~ref_clk;

    usb_dev_irq_output_logic DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .usb_event(usb_event), .pipe_ack(pipe_ack), .pipe_nak(pipe_nak),
        .dma_event(dma_event), .irq_pin(irq_pin));
    irq_host_model host (.ref_clk(ref_clk), .rst(rst), .irq_pin(irq_pin),
        .active_high(pol), .run_len(run_len), .run_count(run_count));

    // =====================================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // a nak interrupts in mode 0 always, in mode 2 only first after an ack
    function automatic logic nak_hits(input int m, input logic first);
        return (m == 0) || (m == 2 && first);
    endfunction
    task automatic give_verdict();
        if (errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic exp);
        checks_done++;
        if (irq_pin !== exp) begin
            errors++;
            $display("mismatch at %0t: pin %h expected %h", $time, irq_pin, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // whole 32-bit word per write, so a clear always covers every byte
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check_val(reg_rdata, exp);
    endtask
    task automatic fire(input logic [15:0] u, input logic [2:0] k, input logic [2:0] n,
                        input logic [15:0] d);
        @(posedge ref_clk);
        usb_event <= u;
        pipe_ack <= k;
        pipe_nak <= n;
        dma_event <= d;
        @(posedge ref_clk);
        usb_event <= 16'h0;
        pipe_ack <= 3'h0;
        pipe_nak <= 3'h0;
        dma_event <= 16'h0;
    endtask

    // hang guard: the whole sequence needs well under this many cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end

    // =====================================================================
    // main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(OFS_MODE, 32'h0);
        rd_chk(OFS_CFG, 32'h0);
        rd_chk(OFS_USB_STATUS, 32'h0);
        rd_chk(OFS_DMA_REASON, 32'h0);
        rd_chk(8'h40, 32'h0);
        check_pin(1'b1);
        // register widths: bits above the register read zero
        wr(OFS_MODE, 32'hffff_ffff);
        rd_chk(OFS_MODE, 32'h0000_ffff);
        wr(OFS_CFG, 32'hffff_ffff);
        rd_chk(OFS_CFG, 32'h0000_00ff);
        wr(OFS_MODE, 32'h0);
        wr(OFS_CFG, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        wr(OFS_USB_EN, 32'hffff_ffff);
        wr(OFS_DMA_EN, 32'hffff_ffff);
        rd_chk(OFS_DMA_EN, 32'h0000_ffff);
        // latched while globally disabled, then enabled, then disabled again
        rnd = lfsr(rnd);
        b = int'(rnd[3:0]);
        fire(16'h1 << b, 3'h0, 3'h0, 16'h0);
        idle(4);
        check_pin(1'b1);
        rd_chk(OFS_USB_STATUS, 32'h1 << b);
        wr(OFS_MODE, 32'h1 << MODE_GLOBAL_EN_BIT);
        idle(3);
        check_pin(1'b0);
        wr(OFS_MODE, 32'h0);
        idle(4);
        check_pin(1'b0);
        wr(OFS_USB_STATUS, 32'h0);
        rd_chk(OFS_USB_STATUS, 32'h1 << b);
        check_pin(1'b0);
        // clear write and a new event on the same bit in one cycle
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= OFS_USB_STATUS;
        reg_wdata <= 32'h1 << b;
        usb_event <= 16'h1 << b;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        usb_event <= 16'h0;
        rd_chk(OFS_USB_STATUS, 32'h1 << b);
        wr(OFS_USB_STATUS, 32'hffff_ffff);
        idle(3);
        check_pin(1'b1);
        wr(OFS_MODE, 32'h1 << MODE_GLOBAL_EN_BIT);
        // masked event stays latched but silent
        wr(OFS_USB_EN, 32'h0);
        fire(16'h1 << b, 3'h0, 3'h0, 16'h0);
        idle(4);
        check_pin(1'b1);
        wr(OFS_USB_EN, 32'hffff_ffff);
        idle(3);
        check_pin(1'b0);
        wr(OFS_USB_STATUS, 32'hffff_ffff);
        // dma event path
        rnd = lfsr(rnd);
        b2 = int'(rnd[3:0]);
        fire(16'h0, 3'h0, 3'h0, 16'h1 << b2);
        idle(4);
        check_pin(1'b0);
        rd_chk(OFS_DMA_REASON, 32'h1 << b2);
        wr(OFS_DMA_REASON, 32'hffff_ffff);
        idle(3);
        check_pin(1'b1);
        // every pipe in every mode: ack, first nak, second nak
        for (int p = 0; p < PIPE_N; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(OFS_CFG, 32'(m) << (CFG_CTRL_LSB + 2 * p));
                fire(16'h0, 3'h1 << p, 3'h0, 16'h0);
                rd_chk(OFS_USB_STATUS, 32'h1 << (USB_PIPE_LSB + p));
                wr(OFS_USB_STATUS, 32'hffff_ffff);
                for (int k = 1; k >= 0; k--) begin
                    fire(16'h0, 3'h0, 3'h1 << p, 16'h0);
                    rd_chk(OFS_USB_STATUS, nak_hits(m, k[0]) ?
                        (32'h1 << (USB_PIPE_LSB + p)) : 32'h0);
                    wr(OFS_USB_STATUS, 32'hffff_ffff);
                end
            end
        end
        // active high level mode
        wr(OFS_CFG, 32'h1 << CFG_POL_BIT);
        pol <= 1'b1;
        idle(3);
        check_pin(1'b0);
        fire(16'h1 << b, 3'h0, 3'h0, 16'h0);
        idle(4);
        check_pin(1'b1);
        wr(OFS_USB_STATUS, 32'hffff_ffff);
        // pulse mode: one pulse per rise, none while already pending
        wr(OFS_CFG, 32'h3);
        idle(4);
        c0 = run_count;
        fire(16'h1 << b, 3'h0, 3'h0, 16'h0);
        idle(10);
        check_val({24'h0, run_count}, {24'h0, c0 + 8'h01});
        check_val({24'h0, run_len}, 32'(PULSE_CYCLES));
        fire(16'h1 << (b ^ 1), 3'h0, 3'h0, 16'h0);
        idle(10);
        check_val({24'h0, run_count}, {24'h0, c0 + 8'h01});
        wr(OFS_USB_STATUS, 32'hffff_ffff);
        fire(16'h0, 3'h0, 3'h0, 16'h1 << b2);
        idle(10);
        check_val({24'h0, run_count}, {24'h0, c0 + 8'h02});
        // no pulse with the global enable off
        wr(OFS_DMA_REASON, 32'hffff_ffff);
        wr(OFS_MODE, 32'h0);
        fire(16'h1 << b, 3'h0, 3'h0, 16'h0);
        idle(10);
        check_val({24'h0, run_count}, {24'h0, c0 + 8'h02});
        // second reset in mid-run restores the defaults
        @(posedge ref_clk);
        rst <= 1'b1;
        pol <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        idle(1);
        check_pin(1'b1);
        rd_chk(OFS_CFG, 32'h0);
        give_verdict();
    end
endmodule
